//--- dv/core_vector_model.sv
module core_vector_model
  import vector_map_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [NUM_SRC-1:0] raise,
  input wire logic [1:0] ackDelay,
  input wire logic irqPending,
  input wire logic [IDX_W-1:0] vectorIdx,
  output logic [NUM_SRC-1:0] irqReq,
  output logic vectorAck
);
  logic [1:0] waitCnt;
  // ==========================================================
  // sources hold requests until the core takes their vector
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqReq <= '0;
      vectorAck <= 1'b0;
      waitCnt <= '0;
    end else begin
      vectorAck <= 1'b0;
      irqReq <= irqReq | raise;
      if (irqPending && !vectorAck) begin
        // a slow core lets the vector stand for a few cycles
        if (waitCnt == ackDelay) begin
          vectorAck <= 1'b1;
          irqReq[vectorIdx] <= 1'b0;
          waitCnt <= '0;
        end else begin
          waitCnt <= waitCnt + 2'h1;
        end
      end
    end
  end
endmodule : core_vector_model

//--- dv/interrupt_vector_address_map_tb.sv
module interrupt_vector_address_map_tb
  import vector_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, bootResetFuse = 1'b1;
  logic vectorTableSelect = 1'b0, vectorAck, irqPending, watchdogFlagClear;
  logic [NUM_SRC-1:0] raise = '0, irqReq;
  logic [1:0] ackDelay = 2'h0;
  logic [ADDR_W-1:0] resetVector, tableStart, vectorAddr;
  logic [IDX_W-1:0] vectorIdx;
  int errTotal = 0, testsRun = 0;
  typedef struct {int idx; logic sel; logic [ADDR_W-1:0] addr;} row_t;
  row_t rows[40];
  interrupt_vector_address_map i_interrupt_vector_address_map (.sys_clk(sys_clk),
    .rst_n(rst_n), .clkEn(clkEn), .bootResetFuse(bootResetFuse),
    .vectorTableSelect(vectorTableSelect), .irqReq(irqReq), .vectorAck(vectorAck),
    .resetVector(resetVector), .tableStart(tableStart), .irqPending(irqPending),
    .vectorAddr(vectorAddr), .vectorIdx(vectorIdx), .watchdogFlagClear(watchdogFlagClear));
  core_vector_model i_core_vector_model (.sys_clk(sys_clk), .rst_n(rst_n), .raise(raise),
    .ackDelay(ackDelay), .irqPending(irqPending), .vectorIdx(vectorIdx), .irqReq(irqReq),
    .vectorAck(vectorAck));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // checking
  task automatic chk(input string what, input logic [ADDR_W-1:0] exp,
                     input logic [ADDR_W-1:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic service(input logic [NUM_SRC-1:0] mask, input int idx, input logic sel,
                         input logic [ADDR_W-1:0] exp);
    int n;
    vectorTableSelect <= sel;
    repeat (2) @(posedge sys_clk);
    raise <= mask;
    @(posedge sys_clk);
    raise <= '0;
    for (n = 0; n < 20 && irqPending !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("vectorAddr", exp, vectorAddr);
    chk("vectorIdx", ADDR_W'(idx), ADDR_W'(vectorIdx));
    for (n = 0; n < 20 && irqPending !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("watchdogFlagClear", ADDR_W'(idx == 7), ADDR_W'(watchdogFlagClear));
  endtask : service
  task automatic conclude();
    $display("checks %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (5000) @(posedge sys_clk);
    errTotal++;
    conclude();
  end
  // ==========================================================
  // main sequence
  initial begin
    for (int i = 0; i < 40; i++) begin
      rows[i].idx = (i < NUM_SRC) ? i : (i - NUM_SRC) * 6 + 3;
      rows[i].sel = (i >= NUM_SRC);
      rows[i].addr = (rows[i].sel ? BOOT_RESET_DEFAULT : 17'h00000) + 17'h00002
                     + 17'(2 * rows[i].idx);
    end
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("resetVector", RESET_ADDR, resetVector);
    chk("tableStart", TABLE_BASE, tableStart);
    foreach (rows[i]) begin
      ackDelay <= 2'(i);
      service(NUM_SRC'(1) << rows[i].idx, rows[i].idx, rows[i].sel, rows[i].addr);
    end
    ackDelay <= 2'h2;
    service((NUM_SRC'(1) << 20) | (NUM_SRC'(1) << 3), 3, 1'b0, 17'h00008);
    service('0, 20, 1'b0, 17'h0002a);
    vectorTableSelect <= 1'b1;
    @(posedge sys_clk);
    clkEn <= 1'b0;
    raise <= NUM_SRC'(1);
    repeat (4) @(posedge sys_clk);
    raise <= '0;
    #1;
    chk("frozen irqPending", '0, ADDR_W'(irqPending));
    clkEn <= 1'b1;
    service('0, 0, 1'b1, BOOT_RESET_DEFAULT + 17'h00002);
    chk("boot tableStart", BOOT_RESET_DEFAULT + 17'h00002, tableStart);
    bootResetFuse <= FUSE_PROGRAMMED;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("boot resetVector", BOOT_RESET_DEFAULT, resetVector);
    bootResetFuse <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("plain resetVector", RESET_ADDR, resetVector);
    conclude();
  end
endmodule : interrupt_vector_address_map_tb

//--- inc/vector_map_pkg.sv
package vector_map_pkg;
  // ==========================================================
  // vector table layout
  localparam int ADDR_W = 17;
  localparam int NUM_SRC = 34;
  localparam int IDX_W = 6;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000;
  localparam logic [ADDR_W-1:0] TABLE_BASE = 17'h00002;
  localparam logic [ADDR_W-1:0] BOOT_RESET_DEFAULT = 17'h1f000;
  // source index of the watchdog time-out request (vector 9)
  localparam logic [IDX_W-1:0] WDT_IDX = 6'h07;
  // sources from this index upward exist only with timer/counter 3
  localparam logic [IDX_W-1:0] TC3_FIRST_IDX = 6'h1e;
  localparam logic FUSE_PROGRAMMED = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRESENT = 3'b010,
    ST_WAIT = 3'b100
  } disp_state_t;
endpackage : vector_map_pkg

//--- rtl/interrupt_vector_address_map.sv
module interrupt_vector_address_map
  import vector_map_pkg::*;
#(
  parameter bit HAS_TC3 = 1'b1,
  parameter logic [ADDR_W-1:0] BOOT_RESET_ADDR = BOOT_RESET_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic bootResetFuse,
  input wire logic vectorTableSelect,
  input wire logic [NUM_SRC-1:0] irqReq,
  input wire logic vectorAck,
  output logic [ADDR_W-1:0] resetVector,
  output logic [ADDR_W-1:0] tableStart,
  output logic irqPending,
  output logic [ADDR_W-1:0] vectorAddr,
  output logic [IDX_W-1:0] vectorIdx,
  output logic watchdogFlagClear
);

  // ==========================================================
  // elaboration checks
  // the table is built of two-word entries, so the boot base must stay even
  if (BOOT_RESET_ADDR[0] != 1'b0) begin : g_bad_boot
    $error("boot reset address must be word pair aligned");
  end
  // the index field must reach every source
  if ((1 << IDX_W) < NUM_SRC) begin : g_bad_idx
    $error("index field too narrow for the source count");
  end

  // ==========================================================
  // fuse capture and address placement
  logic fuseMeta_ff;
  logic fuseLevel_ff;
  logic fuseProg;
  logic [ADDR_W-1:0] resetVector_ff;
  logic [ADDR_W-1:0] tableStart_ff;

  // the fuse is a static strap from outside the clock domain: two flops before use
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fuseMeta_ff <= ~FUSE_PROGRAMMED;
      fuseLevel_ff <= ~FUSE_PROGRAMMED;
    end else if (clkEn) begin
      fuseMeta_ff <= bootResetFuse;
      fuseLevel_ff <= fuseMeta_ff;
    end
  end
  assign fuseProg = (fuseLevel_ff == FUSE_PROGRAMMED);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      resetVector_ff <= RESET_ADDR;
      tableStart_ff <= TABLE_BASE;
    end else if (clkEn) begin
      resetVector_ff <= fuseProg ? BOOT_RESET_ADDR : RESET_ADDR;
      tableStart_ff <= vectorTableSelect ? ADDR_W'(BOOT_RESET_ADDR + TABLE_BASE)
                                         : TABLE_BASE;
    end
  end
  assign resetVector = resetVector_ff;
  assign tableStart = tableStart_ff;

  // ==========================================================
  // priority pick
  logic [NUM_SRC-1:0] reqMask;
  logic found;
  logic [IDX_W-1:0] pickIdx;

  // timer/counter 3 lines are dead on variants without it
  always_comb begin
    for (int i = 0; i < NUM_SRC; i++) begin
      reqMask[i] = irqReq[i] & (HAS_TC3 || (IDX_W'(i) < TC3_FIRST_IDX));
    end
  end

  // lowest index wins: scan downward so the last hit is the lowest
  always_comb begin
    found = 1'b0;
    pickIdx = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (reqMask[i]) begin
        found = 1'b1;
        pickIdx = IDX_W'(i);
      end
    end
  end

  function automatic logic [ADDR_W-1:0] vec_addr(input logic [ADDR_W-1:0] base,
                                                 input logic [IDX_W-1:0] idx);
    vec_addr = ADDR_W'(base + {idx, 1'b0});
  endfunction : vec_addr

  // ==========================================================
  // dispatch
  disp_state_t state_ff;
  disp_state_t nxt_state;
  logic [IDX_W-1:0] vectorIdx_ff;
  logic [ADDR_W-1:0] vectorAddr_ff;
  logic wdClr_ff;

  always_comb begin
    case (state_ff)
      ST_IDLE: nxt_state = found ? ST_PRESENT : ST_IDLE;
      ST_PRESENT: nxt_state = vectorAck ? ST_WAIT : ST_PRESENT;
      ST_WAIT: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else if (clkEn) begin
      state_ff <= nxt_state;
    end
  end

  // the presented vector is frozen while the core fetches it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vectorIdx_ff <= '0;
      vectorAddr_ff <= TABLE_BASE;
    end else if (clkEn && state_ff == ST_IDLE && found) begin
      vectorIdx_ff <= pickIdx;
      vectorAddr_ff <= vec_addr(tableStart_ff, pickIdx);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wdClr_ff <= 1'b0;
    end else if (clkEn) begin
      wdClr_ff <= (state_ff == ST_PRESENT) && vectorAck && (vectorIdx_ff == WDT_IDX);
    end
  end

  assign irqPending = (state_ff == ST_PRESENT);
  assign vectorIdx = vectorIdx_ff;
  assign vectorAddr = vectorAddr_ff;
  assign watchdogFlagClear = wdClr_ff;

  // ==========================================================
  // per-source table offsets, kept apart from the address arithmetic so that
  // the checks below do not merely repeat the adder
  localparam logic [ADDR_W-1:0] SRC_OFFSET [NUM_SRC] = '{
    17'h00002, 17'h00004, 17'h00006,
    17'h00008, 17'h0000a, 17'h0000c, 17'h0000e,
    17'h00010,
    17'h00012, 17'h00014, 17'h00016,
    17'h00018, 17'h0001a, 17'h0001c, 17'h0001e,
    17'h00020, 17'h00022, 17'h00024,
    17'h00026,
    17'h00028, 17'h0002a, 17'h0002c,
    17'h0002e, 17'h00030, 17'h00032, 17'h00034, 17'h00036,
    17'h00038, 17'h0003a, 17'h0003c,
    17'h0003e, 17'h00040, 17'h00042, 17'h00044
  };

  // ==========================================================
  // checks
  property p_rst_vec;
    @(posedge sys_clk) disable iff (!rst_n)
      (clkEn && $past(clkEn) && rst_n && $past(rst_n) && $past(fuseProg))
        |-> resetVector == BOOT_RESET_ADDR;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector not boot address");

  property p_rst_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      ($past(clkEn) && $past(rst_n) && !$past(fuseProg)) |-> resetVector == RESET_ADDR;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset vector not zero");

  property p_table;
    @(posedge sys_clk) disable iff (!rst_n)
      ($past(clkEn) && $past(rst_n))
        |-> tableStart == ($past(vectorTableSelect) ? ADDR_W'(BOOT_RESET_ADDR + TABLE_BASE)
                                                     : TABLE_BASE);
  endproperty
  a_table: assert property (p_table) else $error("table start wrong");

  property p_addr;
    @(posedge sys_clk) disable iff (!rst_n)
      irqPending |-> vectorAddr[0] == 1'b0;
  endproperty
  a_addr: assert property (p_addr) else $error("vector address odd");

  sequence s_take;
    state_ff == ST_IDLE && found && clkEn;
  endsequence
  property p_prio;
    @(posedge sys_clk) disable iff (!rst_n)
      s_take ##1 1'b1 |-> vectorIdx == $past(pickIdx) && (($past(reqMask) &
        ((NUM_SRC'(1) << $past(pickIdx)) - NUM_SRC'(1))) == '0);
  endproperty
  a_prio: assert property (p_prio) else $error("not lowest pending");

  property p_map;
    @(posedge sys_clk) disable iff (!rst_n)
      s_take ##1 1'b1 |->
        vectorAddr == ADDR_W'($past(tableStart_ff) - TABLE_BASE + SRC_OFFSET[vectorIdx]);
  endproperty
  a_map: assert property (p_map) else $error("vector address not in table");

  property p_answer;
    @(posedge sys_clk) disable iff (!rst_n)
      s_take |=> irqPending;
  endproperty
  a_answer: assert property (p_answer) else $error("pending request not presented");

  property p_rst_out;
    @(posedge sys_clk) disable iff (!rst_n)
      !$past(rst_n) |-> !irqPending && vectorIdx == '0 && vectorAddr == TABLE_BASE
        && !watchdogFlagClear && resetVector == RESET_ADDR && tableStart == TABLE_BASE;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not at reset values");

  // a core that is slow to fetch must still see the same vector
  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
      (irqPending && !vectorAck && clkEn) |=>
        irqPending && $stable(vectorAddr) && $stable(vectorIdx);
  endproperty
  a_hold: assert property (p_hold) else $error("presented vector moved");

  sequence s_gap;
    !irqPending ##1 !irqPending;
  endsequence
  property p_gap;
    @(posedge sys_clk) disable iff (!rst_n)
      (irqPending && vectorAck && clkEn) |=> s_gap;
  endproperty
  a_gap: assert property (p_gap) else $error("dispatch too soon after ack");

  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_n)
      !clkEn |=> $stable(irqPending) && $stable(vectorAddr) && $stable(resetVector)
        && $stable(tableStart) && $stable(watchdogFlagClear);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  property p_idx;
    @(posedge sys_clk) disable iff (!rst_n)
      irqPending |-> vectorIdx < IDX_W'(NUM_SRC);
  endproperty
  a_idx: assert property (p_idx) else $error("index beyond source count");

  property p_onehot;
    @(posedge sys_clk) disable iff (!rst_n)
      $onehot(state_ff);
  endproperty
  a_onehot: assert property (p_onehot) else $error("dispatch state not one-hot");

  property p_tc3;
    @(posedge sys_clk) disable iff (!rst_n)
      (!HAS_TC3 && irqPending) |-> vectorIdx < TC3_FIRST_IDX;
  endproperty
  a_tc3: assert property (p_tc3) else $error("absent timer dispatched");

  sequence s_wd_ack;
    irqPending && vectorAck && clkEn && vectorIdx == WDT_IDX;
  endsequence
  property p_wdclr;
    @(posedge sys_clk) disable iff (!rst_n)
      s_wd_ack |=> watchdogFlagClear;
  endproperty
  a_wdclr: assert property (p_wdclr) else $error("watchdog flag not cleared");

  property p_clr_pulse;
    @(posedge sys_clk) disable iff (!rst_n)
      (watchdogFlagClear && clkEn) |=> !watchdogFlagClear;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("flag clear too long");

  property p_wdonly;
    @(posedge sys_clk) disable iff (!rst_n)
      watchdogFlagClear |-> $past(vectorIdx) == WDT_IDX && $past(vectorAck);
  endproperty
  a_wdonly: assert property (p_wdonly) else $error("spurious watchdog clear");

endmodule : interrupt_vector_address_map
